//--- hdl/ftsa_consts.svh
/*
 * Constants for the flow-through synchronous memory access controller:
 * widths, reset values and timing counts.
 * Assumes a single 100 MHz clock; included by its bare name.
 */
`ifndef FTSA_CONSTS_SVH
`define FTSA_CONSTS_SVH

// Summary of operation
// - Register all synchronous inputs on rising clock.
// - Clock gate high freezes all state; the read FIFO still drains and the scan path still shifts.
// - Access needs all three chip selects active.
// - Load low while selected latches address.
// - Write enable low writes, high reads.
// - Byte selects choose which bytes write.
// - Writes complete internally self-timed.
// - Reads, writes, deselects pipelined every edge.
// - Read start conditions at rising edge.
// - Read address registered, drives array; the code reads the array with the unregistered address and registers the data.
// - Read data valid within 6.5 ns.
// - Output enable low needed to receive data.
// - Next operation accepted on following edge.
// - Deselect tri-states data outputs immediately.
// - Scan output shifts on test clock fall.
// - Scan inputs sampled on test clock rise.
// - Selects a,c active low; b high.
// - Output enable asynchronous active low.
// - Float pins on write, after deselect.
// - Clock gate high does not deselect.

`define FTSA_ADDR_W 8
`define FTSA_BYTES 4
`define FTSA_FIFO_DEPTH 16
`define FTSA_CLK_PERIOD_PS 10000
`define FTSA_DATA_VALID_PS 6500
`define FTSA_DATA_VALID_CYC ((`FTSA_DATA_VALID_PS) / (`FTSA_CLK_PERIOD_PS) < 1 ? 1 : (`FTSA_DATA_VALID_PS) / (`FTSA_CLK_PERIOD_PS))
`define FTSA_SCAN_LEN 8
`define FTSA_SCAN_RESET 8'h00

`endif

//--- hdl/ftsa_ctrl.sv
/*
 * Access control of a flow-through synchronous burst memory: clock
 * qualification, chip select, address latch, read/write with byte
 * selects, data pin drive and a small boundary-scan shift path.
 * Assumes the controller drives the pins synchronously to clock;
 * read data leave through a FIFO the user side drains.
 */
`timescale 1ns/10ps
`include "ftsa_consts.svh"
module ftsa_ctrl
#(
	parameter int ADDR_W = `FTSA_ADDR_W,
	parameter int BYTES = `FTSA_BYTES,
	parameter int FIFO_DEPTH = `FTSA_FIFO_DEPTH
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic clock_gate_n,
	input wire logic chip_select_a_n,
	input wire logic chip_select_b,
	input wire logic chip_select_c_n,
	input wire logic advance_load_n,
	input wire logic write_enable_n,
	input wire logic [BYTES-1:0] byte_write_select_n,
	input wire logic [ADDR_W-1:0] address,
	input wire logic output_enable_n,
	input wire logic [8*BYTES-1:0] data_in,
	output logic [8*BYTES-1:0] data_out,
	output logic data_oe_n,
	input wire logic [BYTES-1:0] parity_in,
	output logic [BYTES-1:0] parity_out,
	output logic parity_oe_n,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [8*BYTES+BYTES-1:0] rd_data,
	input wire logic test_clock,
	input wire logic test_mode_select,
	input wire logic test_data_in,
	output logic test_data_out,
	output logic scan_mode
);
	import ftsa_pkg::*;

	localparam int W = 9 * BYTES;

	// ****************************************************
	// Input registers and qualification
	// ****************************************************
	logic selected;
	logic start;
	ftsa_op_t op;
	logic [ADDR_W-1:0] addr_q;
	logic [BYTES-1:0] bw_q;
	logic was_deselected;
	logic emerge;
	logic [8:0] mem [BYTES][2**ADDR_W];
	wire logic [W-1:0] rd_word;
	wire logic [BYTES-1:0] fwd;
	logic push;

	assign selected = !chip_select_a_n && chip_select_b && !chip_select_c_n;
	assign start = selected && !advance_load_n;

	// Read words enter the FIFO on the edge that closes their data cycle; a full FIFO drops them.
	// The pin mask after deselect does not apply here, so masked read words still reach the FIFO.
	assign push = (op == ftsa_read);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			op <= ftsa_idle;
			addr_q <= '0;
			bw_q <= '0;
			was_deselected <= 1'b1;
			emerge <= 1'b0;
		end
		else if (!clock_gate_n)
		begin
			// Each qualified edge takes a new operation.
			if (start)
			begin
				op <= write_enable_n ? ftsa_read : ftsa_write;
				addr_q <= address;
				bw_q <= ~byte_write_select_n;
			end
			else if (!selected)
				op <= ftsa_idle;
			else
				op <= ftsa_idle;
			was_deselected <= !selected;
			emerge <= was_deselected && selected;
		end
	end

	// ****************************************************
	// Array: self-timed write, flow-through read
	// ****************************************************
	genvar b;
	generate
		for (b = 0; b < BYTES; b++)
		begin : g_lane
			always_ff @(posedge clock)
			begin
				if (!clock_gate_n && op == ftsa_write && bw_q[b])
					mem[b][addr_q] <= {parity_in[b], data_in[8*b +: 8]};
			end
			// A write landing on this edge at the address being read is forwarded, so the read never sees stale bytes.
			assign fwd[b] = op == ftsa_write && bw_q[b] && addr_q == address;
			assign rd_word[8*b +: 8] = fwd[b] ? data_in[8*b +: 8] : mem[b][address][7:0];
			assign rd_word[8*BYTES + b] = fwd[b] ? parity_in[b] : mem[b][address][8];
		end
	endgenerate

	// ****************************************************
	// Data pins
	// ****************************************************
	// Data registered ahead of the pins: one cycle is within the valid window.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			data_out <= '0;
			parity_out <= '0;
		end
		else if (!clock_gate_n && start && write_enable_n)
		begin
			data_out <= rd_word[8*BYTES-1:0];
			parity_out <= rd_word[W-1:8*BYTES];
		end
	end

	// Output enable is combined asynchronously; internal masking wins.
	assign data_oe_n = output_enable_n || op != ftsa_read || emerge;
	assign parity_oe_n = data_oe_n;

	ftsa_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) u_fifo
	(
		.clock(clock),
		.rst(rst),
		.in_valid(push && !clock_gate_n),
		.in_ready(),
		.in_data({parity_out, data_out}),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	// ****************************************************
	// Boundary-scan shift path
	// ****************************************************
	logic [`FTSA_SCAN_LEN-1:0] scan_reg;

	always_ff @(posedge test_clock or posedge rst)
	begin
		if (rst)
		begin
			scan_reg <= `FTSA_SCAN_RESET;
			scan_mode <= 1'b0;
		end
		else
		begin
			scan_mode <= test_mode_select;
			scan_reg <= {test_data_in, scan_reg[`FTSA_SCAN_LEN-1:1]};
		end
	end

	always_ff @(negedge test_clock or posedge rst)
	begin
		if (rst)
			test_data_out <= 1'b0;
		else
			test_data_out <= scan_reg[0];
	end
endmodule

//--- hdl/ftsa_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/10ps
module ftsa_fifo
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic do_push;
	logic do_pop;

	assign in_ready = (count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid = (count != '0);
	assign do_push = in_valid && in_ready;
	assign do_pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clock)
	begin
		if (do_push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (do_pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			if (do_push && !do_pop)
				count <= count + 1'b1;
			else if (do_pop && !do_push)
				count <= count - 1'b1;
		end
	end
endmodule

//--- hdl/ftsa_pkg.sv
/*
 * Types shared by the access controller.
 * Assumes the constants header is on the include path.
 */
package ftsa_pkg;
	typedef enum logic [1:0]
	{
		ftsa_idle = 2'b00,
		ftsa_read = 2'b01,
		ftsa_write = 2'b10
	} ftsa_op_t;
endpackage

//--- tb/flow_through_sram_access_ctrl_tb.sv
/* Bench for the access controller and its read FIFO.
   Assumes the design header is on the include path. */
`timescale 1ns/10ps
`include "ftsa_consts.svh"
module flow_through_sram_access_ctrl_tb;
	localparam logic [5:0] RD = 6'h09, WR = 6'h08, HOLD = 6'h29, DS = 6'h19;
	logic clock = 1'b0, rst = 1'b1, drive = 1'b0, rd_ready = 1'b1, output_enable_n = 1'b0;
	logic test_clock = 1'b0, test_mode_select = 1'b0, test_data_in = 1'b0;
	logic clock_gate_n, chip_select_a_n, chip_select_b, chip_select_c_n, advance_load_n, write_enable_n;
	logic data_oe_n, parity_oe_n, rd_valid, test_data_out, scan_mode;
	logic [5:0] ctl = DS;
	logic [3:0] byte_write_select_n = 4'h0, parity_in, parity_out;
	logic [7:0] address = 8'h00;
	logic [31:0] data_in, data_out;
	logic [35:0] wdata = 36'h0, bus, rd_data;
	logic [35:0] got[$];
	int n_errors = 0, samples_checked = 0;
	assign {clock_gate_n, chip_select_a_n, chip_select_b, chip_select_c_n, advance_load_n, write_enable_n} = ctl;
	assign {parity_in, data_in} = bus;
	ftsa_ctrl dut_u (.clock(clock), .rst(rst), .clock_gate_n(clock_gate_n), .chip_select_a_n(chip_select_a_n),
		.chip_select_b(chip_select_b), .chip_select_c_n(chip_select_c_n), .advance_load_n(advance_load_n),
		.write_enable_n(write_enable_n), .byte_write_select_n(byte_write_select_n), .address(address),
		.output_enable_n(output_enable_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
		.parity_in(parity_in), .parity_out(parity_out), .parity_oe_n(parity_oe_n), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_data(rd_data), .test_clock(test_clock), .test_mode_select(test_mode_select),
		.test_data_in(test_data_in), .test_data_out(test_data_out), .scan_mode(scan_mode));
	ftsa_bus_model bus_u (.clock(clock), .drive(drive), .wdata(wdata),
		.dev_q({parity_out, data_out}), .dev_oe_n(data_oe_n), .q(bus));
	initial forever #5 clock = ~clock;
	always @(negedge clock)
		if (rd_valid === 1'b1 && rd_ready === 1'b1)
			got.push_back(rd_data);
	task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic go(input logic [5:0] c, input logic [3:0] bw, input logic [7:0] a, input logic [36:0] d);
		ctl <= c;
		byte_write_select_n <= bw;
		address <= a;
		{drive, wdata} <= d;
		@(posedge clock);
	endtask
	task automatic t_rw;
		go(WR, 4'h0, 8'h12, 37'h0);
		go(WR, 4'h0, 8'h34, {1'b1, 36'h9a5a51234});
		go(WR, 4'hd, 8'h12, {1'b1, 36'h60badcafe});
		go(RD, 4'h0, 8'h34, {1'b1, 36'hfffffffff});
		fork
			go(RD, 4'h0, 8'h12, 37'h0);
			begin
				@(negedge clock);
				chk("pin34", bus, 36'h60badcafe);
			end
		join
		go(DS, 4'h0, 8'h00, 37'h0);
		repeat (3) @(posedge clock);
		chk("rd34", got.pop_front(), 36'h60badcafe);
		chk("rd12", got.pop_front(), 36'hba5a5ff34);
	endtask
	task automatic t_gate;
		repeat (3) go(HOLD, 4'h0, 8'h34, 37'h0);
		go(RD, 4'h0, 8'h34, 37'h0);
		fork
			go(DS, 4'h0, 8'h00, 37'h0);
			begin
				@(negedge clock);
				chk("emerge", data_oe_n, 1'b1);
			end
		join
		repeat (3) @(posedge clock);
		chk("gated", got.size(), 1);
		chk("gdata", got.pop_front(), 36'h60badcafe);
	endtask
	task automatic t_desel;
		logic [5:0] ds[3] = '{6'h19, 6'h01, 6'h0d};
		foreach (ds[i])
		begin
			go(RD, 4'h0, 8'h34, 37'h0);
			go(ds[i], 4'h0, 8'h34, 37'h0);
			@(negedge clock);
			chk("float", data_oe_n, 1'b1);
			@(posedge clock);
		end
		repeat (3) @(posedge clock);
		chk("selected", got.size(), 3);
		got.delete();
	endtask
	task automatic t_fifo;
		rd_ready <= 1'b0;
		output_enable_n <= 1'b1;
		repeat (17) go(RD, 4'h0, 8'h12, 37'h0);
		@(negedge clock);
		chk("masked", data_oe_n, 1'b1);
		@(posedge clock);
		go(DS, 4'h0, 8'h00, 37'h0);
		@(posedge clock);
		rd_ready <= 1'b1;
		output_enable_n <= 1'b0;
		repeat (20) @(posedge clock);
		chk("fill", got.size(), `FTSA_FIFO_DEPTH);
		chk("word", got[0], 36'hba5a5ff34);
	endtask
	task automatic t_scan;
		logic [11:0] pat = 12'h5a3;
		for (int i = 0; i < 12; i++)
		begin
			test_mode_select <= i[0];
			test_data_in <= pat[i];
			#20 test_clock <= 1'b1;
			#1 chk("tdo_rise", test_data_out, (i > 7) ? pat[i-8] : 1'b0);
			chk("scan", scan_mode, i[0]);
			#19 test_clock <= 1'b0;
			#1 chk("tdo", test_data_out, (i >= 7) ? pat[i-7] : 1'b0);
			#19;
		end
	endtask
	task automatic end_sim;
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_rw;
		t_gate;
		t_desel;
		t_fifo;
		t_scan;
		end_sim;
	end
	// The scenarios take about 155 cycles; this allows about thirteen times that.
	initial
	begin
		#20000;
		n_errors++;
		end_sim;
	end
endmodule
bind ftsa_ctrl ftsa_ctrl_checker #(.BYTES(BYTES)) chk_u (.clock(clock), .rst(rst), .clock_gate_n(clock_gate_n),
	.chip_select_a_n(chip_select_a_n), .chip_select_b(chip_select_b), .chip_select_c_n(chip_select_c_n),
	.advance_load_n(advance_load_n), .write_enable_n(write_enable_n), .output_enable_n(output_enable_n),
	.data_out(data_out), .parity_out(parity_out), .data_oe_n(data_oe_n), .parity_oe_n(parity_oe_n),
	.rd_valid(rd_valid));

//--- tb/ftsa_bus_model.sv
/* Controller side of the shared data and parity lines.
   Assumes the bench says when write data is driven. */
`timescale 1ns/10ps
module ftsa_bus_model
(
	input wire logic clock,
	input wire logic drive,
	input wire logic [35:0] wdata,
	input wire logic [35:0] dev_q,
	input wire logic dev_oe_n,
	output logic [35:0] q
);
	logic [35:0] last = 36'h0;
	always_ff @(posedge clock)
	begin
		last <= q;
	end
	// A released bus shows the inverse of its last level, so stale data cannot pass.
	assign q = !dev_oe_n ? dev_q : drive ? wdata : ~last;
endmodule

//--- tb/ftsa_ctrl_checker.sv
/* Pin assertions for the access controller.
   Assumes a bind into the controller; one clock. */
`timescale 1ns/10ps
module ftsa_ctrl_checker
#(
	parameter int BYTES = 4
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic clock_gate_n,
	input wire logic chip_select_a_n,
	input wire logic chip_select_b,
	input wire logic chip_select_c_n,
	input wire logic advance_load_n,
	input wire logic write_enable_n,
	input wire logic output_enable_n,
	input wire logic [8*BYTES-1:0] data_out,
	input wire logic [BYTES-1:0] parity_out,
	input wire logic data_oe_n,
	input wire logic parity_oe_n,
	input wire logic rd_valid
);
	logic sel;
	logic go;
	assign sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
	assign go = !clock_gate_n && sel && !advance_load_n;
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence rd_s;
		go && write_enable_n;
	endsequence
	sequence wr_s;
		go && !write_enable_n;
	endsequence
	sequence off_s;
		!clock_gate_n && !sel;
	endsequence
	AST_GATED: assert property (clock_gate_n |=> $stable({data_out, parity_out})) else $error("gated");
	AST_OFF: assert property (off_s |=> data_oe_n && parity_oe_n) else $error("off drive");
	AST_OE: assert property (output_enable_n |-> data_oe_n && parity_oe_n) else $error("oe");
	AST_WR: assert property (wr_s |=> data_oe_n && parity_oe_n) else $error("wr drive");
	AST_EMERGE: assert property (off_s ##1 rd_s |=> data_oe_n) else $error("emerge");
	AST_RD: assert property (rd_s ##1 rd_s |=> output_enable_n || !data_oe_n) else $error("rd");
	AST_PUSH: assert property (rd_s ##1 !clock_gate_n |=> rd_valid) else $error("push");
	AST_KEEP: assert property (clock_gate_n ##1 $stable(output_enable_n) |-> $stable(data_oe_n)) else $error("keep");
endmodule
